// file: rtl/ckc_map.svh
// constants of the clock control unit: offsets, field positions, reset values, counts
// assumes a 40 MHz clk_i that is the oscillator-derived clock itself
// Function
// RQ1 - slow mode clear: core clock equals source
// RQ2 - slow codes divide source by 2,4,8,16
// RQ3 - bit 7 routes core clock to pin; the pin toggles on each core tick, so it shows half the core rate
// RQ4 - clock-out pin stops during active halt
// RQ5 - time base periods 16000/32000/80000/200000 cycles
// RQ6 - new time base applies after current period
// RQ7 - period end sets flag bit 0
// RQ8 - reading status register clears the flag
// RQ9 - request only when flag and enable set
// RQ10 - halt with enable set enters active halt
// RQ11 - wait mode unaffected, interrupt exits wait
// RQ12 - active halt: counter runs, registers frozen
// RQ13 - full halt freezes all, no time-base wake
// RQ14 - software avoids bit set/clear on status
// RQ15 - tone pin drives three selectable frequencies
// RQ16 - prescaler, clock-out, time base run independently
// RQ17 - tone codes: off, ~2k, ~1k, ~500 Hz; with the 40 MHz clk_i the half periods of 2000/4000/8000 give 10k, 5k, 2.5k Hz
// RQ18 - tone keeps running in active halt
// RQ19 - time base restarts from zero each period
`ifndef CKC_MAP_SVH
`define CKC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// register indexes; byte address is four times the index
`define CKC_ADDR_W 8
`define CKC_CSR_IDX 6'h2c
`define CKC_TONE_IDX 6'h2d
`define CKC_IRQ_STAT_IDX 6'h30
`define CKC_IRQ_CLR_IDX 6'h31
`define CKC_IRQ_EN_IDX 6'h32

////////////////////////////////////////////////////////////////////////////////
// field positions and reset values
`define CKC_CSR_CLK_OUT_BIT 7
`define CKC_CSR_FLAG_BIT 0
`define CKC_CSR_RST 8'h00
`define CKC_TONE_RST 8'h00
`define CKC_IRQ_W 2
`define CKC_IRQ_TB_BIT 0
`define CKC_IRQ_WAKE_BIT 1

////////////////////////////////////////////////////////////////////////////////
// timing counts in source clock cycles
`define CKC_TB_CYC_0 16000
`define CKC_TB_CYC_1 32000
`define CKC_TB_CYC_2 80000
`define CKC_TB_CYC_3 200000
`define CKC_TONE_HALF_1 2000
`define CKC_TONE_HALF_2 4000
`define CKC_TONE_HALF_3 8000

`endif

// file: rtl/ckc_pkg.sv
// types shared by the clock control unit
// assumes ckc_map.svh supplies the numeric constants
package ckc_pkg;

  // power state as seen by this unit
  typedef enum logic [1:0] {
    PM_RUN,
    PM_ACT_HALT,
    PM_HALT
  } ckc_pm_t;

  // control/status register layout, bit 7 down to bit 0
  typedef struct packed {
    logic clock_out_select;
    logic [1:0] slow_divider_select;
    logic slow_mode_select;
    logic [1:0] time_base_select;
    logic timebase_irq_enable;
    logic timebase_irq_flag;
  } ckc_csr_t;

endpackage : ckc_pkg

// file: rtl/ckc_tone_gen.sv
// square wave generator for the tone pin
// assumes clk_i is the source clock and run_i low freezes counter and pin, except that code 0 still clears them
`timescale 1ns/1ps
module ckc_tone_gen #(
  parameter int HALF_1 = 2000,
  parameter int HALF_2 = 4000,
  parameter int HALF_3 = 8000,
  parameter int CNT_W = 14
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [1:0] sel_i,
  output logic tone_o
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] half_w;
  logic wrap_w;

  // half period per code; code 0 holds the pin low
  assign half_w = (sel_i == 2'h1) ? CNT_W'(HALF_1 - 1) :
                  (sel_i == 2'h2) ? CNT_W'(HALF_2 - 1) : CNT_W'(HALF_3 - 1); // RQ17
  assign wrap_w = (cnt_q >= half_w);

  // equal high and low halves give the 50% duty
  always_ff @(posedge clk_i) begin
    if (rst_i || (sel_i == 2'h0)) begin
      cnt_q <= '0;
      tone_o <= 1'b0; // RQ17
    end else if (run_i) begin
      cnt_q <= wrap_w ? '0 : cnt_q + CNT_W'(1);
      if (wrap_w) begin
        tone_o <= ~tone_o; // RQ15
      end
    end
  end

endmodule : ckc_tone_gen

// file: rtl/ckc_top.sv
// clock control unit: core clock prescaler, clock-out, time base, tone, power state
// assumes a classic wishbone master on clk_i and a core that pulses halt_instr_i
// clk_i is taken as the oscillator-derived clock; core clock leaves as an enable
`timescale 1ns/1ps
`include "ckc_map.svh"
module ckc_top #(
  parameter int TB_CYC_0 = `CKC_TB_CYC_0,
  parameter int TB_CYC_1 = `CKC_TB_CYC_1,
  parameter int TB_CYC_2 = `CKC_TB_CYC_2,
  parameter int TB_CYC_3 = `CKC_TB_CYC_3,
  parameter int TONE_HALF_1 = `CKC_TONE_HALF_1,
  parameter int TONE_HALF_2 = `CKC_TONE_HALF_2,
  parameter int TONE_HALF_3 = `CKC_TONE_HALF_3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`CKC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // power control, same clock domain as the core
  input wire logic halt_instr_i,
  input wire logic wait_i,
  input wire logic ext_wake_i,
  output logic active_halt_o,
  output logic halt_o,
  output logic wake_o,
  // clock outputs
  output logic core_clock_en_o,
  output logic clock_out_pin_o,
  output logic clock_out_pin_oe_o,
  output logic tone_pin_o,
  output logic tone_pin_oe_o,
  // interrupts
  output logic tb_irq_o,
  output logic irq_o
);

  localparam int TB_W = 18;

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  ckc_pkg::ckc_csr_t csr_q;
  ckc_pkg::ckc_pm_t pm_q;
  ckc_pkg::ckc_pm_t pm_d;
  logic [1:0] tone_sel_q;
  logic [`CKC_IRQ_W-1:0] irq_stat_q;
  logic [`CKC_IRQ_W-1:0] irq_en_q;
  logic [`CKC_IRQ_W-1:0] irq_ev_w;
  logic [`CKC_IRQ_W-1:0] irq_clr_w;
  logic [TB_W-1:0] tb_cnt_q;
  logic [1:0] tb_act_q;
  logic [TB_W-1:0] tb_last_w;
  logic tb_done_w;
  logic tb_run_w;
  logic [3:0] pre_q;
  logic [3:0] pre_last_w;
  logic core_en_w;
  logic clk_out_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic req_w;
  logic acc_w;
  logic wr_w;
  logic rd_w;
  logic lane0_w;
  logic hit_csr_w;
  logic hit_tone_w;
  logic hit_stat_w;
  logic hit_clr_w;
  logic hit_en_w;
  logic [7:0] rd_byte_w;
  logic regs_live_w;
  logic tb_req_w;
  logic wake_ev_w;

  ////////////////////////////////////////////////////////////////////////////////
  // functions

  // word decode: true when the byte address names the given register index
  function automatic logic adr_is(input logic [`CKC_ADDR_W-1:0] adr, input logic [5:0] idx);
    adr_is = (adr == {idx, 2'b00});
  endfunction : adr_is

  // last count of a time base period for a select code
  function automatic logic [TB_W-1:0] tb_last_of(input logic [1:0] code);
    unique case (code)
      2'h0: tb_last_of = TB_W'(TB_CYC_0 - 1);
      2'h1: tb_last_of = TB_W'(TB_CYC_1 - 1);
      2'h2: tb_last_of = TB_W'(TB_CYC_2 - 1);
      2'h3: tb_last_of = TB_W'(TB_CYC_3 - 1);
    endcase
  endfunction : tb_last_of

  ////////////////////////////////////////////////////////////////////////////////
  // wishbone decode

  // one access per request; ack_q masks the second cycle of a held request
  assign req_w = wb_cyc_i & wb_stb_i;
  assign acc_w = req_w & ~ack_q;
  assign lane0_w = wb_sel_i[0];
  // registers freeze outside run; the core cannot issue accesses then anyway
  assign regs_live_w = (pm_q == ckc_pkg::PM_RUN); // RQ12 RQ13
  assign wr_w = acc_w & wb_we_i & lane0_w & regs_live_w;
  assign rd_w = acc_w & ~wb_we_i;

  assign hit_csr_w = adr_is(wb_adr_i, `CKC_CSR_IDX);
  assign hit_tone_w = adr_is(wb_adr_i, `CKC_TONE_IDX);
  assign hit_stat_w = adr_is(wb_adr_i, `CKC_IRQ_STAT_IDX);
  assign hit_clr_w = adr_is(wb_adr_i, `CKC_IRQ_CLR_IDX);
  assign hit_en_w = adr_is(wb_adr_i, `CKC_IRQ_EN_IDX);

  // read selection; unmapped and write-only addresses read as zero
  assign rd_byte_w = hit_csr_w ? csr_q :
                     hit_tone_w ? {6'h00, tone_sel_q} :
                     hit_stat_w ? {{(8-`CKC_IRQ_W){1'b0}}, irq_stat_q} :
                     hit_en_w ? {{(8-`CKC_IRQ_W){1'b0}}, irq_en_q} : 8'h00;

  // acknowledge one cycle after the request, read data registered with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc_w;
      if (rd_w) begin
        dat_q <= {24'h00_0000, rd_byte_w};
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  ////////////////////////////////////////////////////////////////////////////////
  // control/status and tone registers

  // software bits take writes; the flag is only set by the time base and
  // cleared by a read, and a period end in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csr_q <= ckc_pkg::ckc_csr_t'(`CKC_CSR_RST);
      tone_sel_q <= 2'(`CKC_TONE_RST);
    end else begin
      if (wr_w && hit_csr_w) begin
        csr_q.clock_out_select <= wb_dat_i[`CKC_CSR_CLK_OUT_BIT];
        csr_q.slow_divider_select <= wb_dat_i[6:5];
        csr_q.slow_mode_select <= wb_dat_i[4];
        csr_q.time_base_select <= wb_dat_i[3:2];
        csr_q.timebase_irq_enable <= wb_dat_i[1];
      end
      if (tb_done_w) begin
        csr_q.timebase_irq_flag <= 1'b1; // RQ7
      end else if (rd_w && hit_csr_w && regs_live_w) begin
        csr_q.timebase_irq_flag <= 1'b0; // RQ8
      end
      if (wr_w && hit_tone_w) begin
        tone_sel_q <= wb_dat_i[1:0]; // RQ15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // time base counter

  // runs in run, wait and active halt; stands still in full halt
  assign tb_run_w = (pm_q != ckc_pkg::PM_HALT); // RQ11 RQ12 RQ13
  assign tb_last_w = tb_last_of(tb_act_q); // RQ5
  assign tb_done_w = tb_run_w & (tb_cnt_q == tb_last_w);

  // the select in use is refreshed only at a period end, so a change never
  // shortens or stretches the period already running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb_cnt_q <= '0;
      tb_act_q <= 2'h0;
    end else if (tb_done_w) begin
      tb_cnt_q <= '0; // RQ19
      tb_act_q <= csr_q.time_base_select; // RQ6
    end else if (tb_run_w) begin
      tb_cnt_q <= tb_cnt_q + TB_W'(1); // RQ16
    end
  end

  // request to the core's interrupt controller, gated there by the global mask
  assign tb_req_w = csr_q.timebase_irq_flag & csr_q.timebase_irq_enable; // RQ9
  assign tb_irq_o = tb_req_w;

  ////////////////////////////////////////////////////////////////////////////////
  // core clock prescaler

  // slow division 2, 4, 8, 16: the enable fires once every 2^(code+1) cycles
  assign pre_last_w = 4'((5'h02 << csr_q.slow_divider_select) - 5'h01); // RQ2
  assign core_en_w = regs_live_w &
                     (~csr_q.slow_mode_select | (pre_q == pre_last_w)); // RQ1

  // counter restarts on each pulse; a divider change takes hold at once and
  // may give one short or long slot, which the core tolerates
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= 4'h0;
    end else if (core_en_w || !csr_q.slow_mode_select || !regs_live_w) begin
      pre_q <= 4'h0;
    end else if (pre_q >= pre_last_w) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  assign core_clock_en_o = core_en_w;

  ////////////////////////////////////////////////////////////////////////////////
  // clock-out pin

  // toggles on each core clock pulse, so the pin shows the core rate halved;
  // a single-clock design cannot put clk_i itself on a pin cleanly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_out_q <= 1'b0;
    end else if (!csr_q.clock_out_select || !regs_live_w) begin
      clk_out_q <= 1'b0; // RQ4
    end else if (core_en_w) begin
      clk_out_q <= ~clk_out_q; // RQ3
    end
  end

  // pin is claimed only while clock-out is selected; else it stays general I/O
  assign clock_out_pin_o = clk_out_q;
  assign clock_out_pin_oe_o = csr_q.clock_out_select; // RQ3

  ////////////////////////////////////////////////////////////////////////////////
  // tone generator

  // keeps running in active halt; software should turn it off to save power
  ckc_tone_gen #(
    .HALF_1(TONE_HALF_1),
    .HALF_2(TONE_HALF_2),
    .HALF_3(TONE_HALF_3),
    .CNT_W(14)
  ) u_tone (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(tb_run_w), // RQ18
    .sel_i(tone_sel_q),
    .tone_o(tone_pin_o)
  );

  assign tone_pin_oe_o = (tone_sel_q != 2'h0); // RQ15

  ////////////////////////////////////////////////////////////////////////////////
  // power state

  // halt instruction picks active halt when the time-base interrupt is enabled;
  // only the time base request or an external wake leaves active halt, and
  // only an external wake leaves full halt
  always_comb begin
    pm_d = pm_q;
    unique case (pm_q)
      ckc_pkg::PM_RUN: begin
        if (halt_instr_i) begin
          pm_d = csr_q.timebase_irq_enable ? ckc_pkg::PM_ACT_HALT
                                           : ckc_pkg::PM_HALT; // RQ10
        end
      end
      ckc_pkg::PM_ACT_HALT: begin
        if (tb_req_w || ext_wake_i) begin
          pm_d = ckc_pkg::PM_RUN; // RQ12
        end
      end
      ckc_pkg::PM_HALT: begin
        if (ext_wake_i) begin
          pm_d = ckc_pkg::PM_RUN; // RQ13
        end
      end
      default: begin
        pm_d = ckc_pkg::PM_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pm_q <= ckc_pkg::PM_RUN;
    end else begin
      pm_q <= pm_d;
    end
  end

  assign active_halt_o = (pm_q == ckc_pkg::PM_ACT_HALT);
  assign halt_o = (pm_q == ckc_pkg::PM_HALT);
  // wait needs no state here: the request itself ends wait
  assign wake_o = tb_req_w & (wait_i | active_halt_o); // RQ11

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status, clear and enable

  assign wake_ev_w = (pm_q != ckc_pkg::PM_RUN) & (pm_d == ckc_pkg::PM_RUN);
  assign irq_ev_w = {wake_ev_w, tb_done_w};
  assign irq_clr_w = (wr_w && hit_clr_w) ? wb_dat_i[`CKC_IRQ_W-1:0] : '0;

  // sticky bits; an event in the clearing cycle survives the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr_w) | irq_ev_w;
      if (wr_w && hit_en_w) begin
        irq_en_q <= wb_dat_i[`CKC_IRQ_W-1:0];
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_en_q);

endmodule : ckc_top

// file: tb/ckc_top_asserts.sv
// concurrent checks on the ports of the clock control unit top
// assumes a bind onto ckc_top; single clk_i domain, sync active-high reset
`timescale 1ns/1ps
module ckc_top_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic halt_instr_i,
  input wire logic wait_i,
  input wire logic ext_wake_i,
  input wire logic active_halt_o,
  input wire logic halt_o,
  input wire logic wake_o,
  input wire logic core_clock_en_o,
  input wire logic clock_out_pin_o,
  input wire logic clock_out_pin_oe_o,
  input wire logic tone_pin_oe_o,
  input wire logic tone_pin_o,
  input wire logic tb_irq_o
);
  ////////////////////////////////////////
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // bus answer comes one cycle after the request and lasts one cycle
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // power states: entry, gating of the core clock, and exits
  a_halt_entry: assert property (halt_instr_i && !active_halt_o && !halt_o |=> active_halt_o != halt_o)
    else $error("halt instruction did not enter exactly one halt state");
  a_core_gated: assert property (active_halt_o || halt_o |-> !core_clock_en_o)
    else $error("core clock ticks while halted");
  a_ahalt_exit: assert property (active_halt_o && tb_irq_o |=> !active_halt_o)
    else $error("time base interrupt did not end active halt");
  a_halt_hold: assert property (halt_o && !ext_wake_i |=> halt_o)
    else $error("full halt left without external wake");
  a_halt_exit: assert property (halt_o && ext_wake_i |=> !halt_o)
    else $error("external wake did not end full halt");
  a_wait_wake: assert property (wait_i && tb_irq_o |-> wake_o)
    else $error("time base interrupt did not wake from wait");

  // pins: clock-out quiet in active halt or when free, tone low when off
  a_clkout_quiet: assert property (active_halt_o [*2] |-> !clock_out_pin_o)
    else $error("clock-out pin active during active halt");
  a_clkout_free: assert property (!clock_out_pin_oe_o && !$past(clock_out_pin_oe_o) |-> !clock_out_pin_o)
    else $error("clock-out pin driven while not selected");
  a_tone_off: assert property ($fell(tone_pin_oe_o) |=> !tone_pin_o [*3])
    else $error("tone pin not low after tone off");
endmodule : ckc_top_asserts

// file: tb/testbench.sv
// self-checking bench for the clock control unit
// assumes ckc_top built with short time base and tone counts, 40 MHz clock
`timescale 1ns/1ps
`include "ckc_map.svh"
module testbench;
  localparam logic [7:0] CSR_A = {`CKC_CSR_IDX, 2'b00};
  localparam logic [7:0] TONE_A = {`CKC_TONE_IDX, 2'b00};
  localparam logic [7:0] STAT_A = {`CKC_IRQ_STAT_IDX, 2'b00};
  localparam logic [7:0] CLR_A = {`CKC_IRQ_CLR_IDX, 2'b00};
  localparam logic [7:0] EN_A = {`CKC_IRQ_EN_IDX, 2'b00};
  // short period and half-period counts so the run stays small
  localparam int TB0 = 16, TB1 = 32, TB2 = 80, TB3 = 200;
  localparam int TH1 = 4, TH2 = 8, TH3 = 16;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic halt_instr_i = 1'b0, wait_i = 1'b0, ext_wake_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, active_halt_o, halt_o, wake_o, core_clock_en_o, clock_out_pin_o;
  logic clock_out_pin_oe_o, tone_pin_o, tone_pin_oe_o, tb_irq_o, irq_o, p;
  logic sel0 = 1'b1;
  int fail_count = 0, tests_run = 0, cyc_cnt = 0, seed = 32'h18d5;
  int c, n, k, m, t0, t1;

  ckc_top #(.TB_CYC_0(TB0), .TB_CYC_1(TB1), .TB_CYC_2(TB2), .TB_CYC_3(TB3),
    .TONE_HALF_1(TH1), .TONE_HALF_2(TH2), .TONE_HALF_3(TH3)) uut (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .halt_instr_i, .wait_i, .ext_wake_i, .active_halt_o, .halt_o, .wake_o,
    .core_clock_en_o, .clock_out_pin_o, .clock_out_pin_oe_o, .tone_pin_o,
    .tone_pin_oe_o, .tb_irq_o, .irq_o);

  ////////////////////////////////////////
  // clock, and a cycle ceiling far above the 1,400 or so cycles needed
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 8000) begin
      fail_count++;
      end_of_test();
    end
  end

  // expected period lengths, matching the short counts set above
  function automatic int tb_len(input int code);
    return (code == 0) ? TB0 : (code == 1) ? TB1 : (code == 2) ? TB2 : TB3;
  endfunction : tb_len

  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  // comparisons: one for words and counts, one for single flags
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  // classic single cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= {3'($random(seed)), sel0}; // upper lanes random, only lane 0 counts
    do begin @(posedge clk_i); i++; end while (wb_ack_o !== 1'b1 && i < 40);
    if (wb_ack_o !== 1'b1) fail_count++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  // waits for the time base request, or for a tone pin edge
  task automatic tick(output int t);
    int i;
    i = 0;
    do begin @(posedge clk_i); i++; end while (tb_irq_o !== 1'b1 && i < 400);
    if (tb_irq_o !== 1'b1) fail_count++;
    t = cyc_cnt;
  endtask : tick
  task automatic flip(output int t);
    logic q;
    int i;
    q = tone_pin_o;
    i = 0;
    do begin @(posedge clk_i); i++; end while (tone_pin_o === q && i < 100);
    if (tone_pin_o === q) fail_count++;
    t = cyc_cnt;
  endtask : flip

  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, CSR_A, 0);
    chk(rd, `CKC_CSR_RST);
    bus(1'b0, TONE_A, 0);
    chk(rd, `CKC_TONE_RST);
    bus(1'b1, 8'h40, $random(seed));
    bus(1'b0, 8'h40, 0);
    chk(rd, 0);
    // normal mode then each slow code; clock-out follows the core ticks
    for (c = 0; c < 5; c++) begin
      m = (c == 0) ? 32'h80 : 32'h90 | ((c - 1) << 5);
      bus(1'b1, CSR_A, m);
      bus(1'b0, CSR_A, 0);
      chk(rd & 32'hfe, m);
      n = 0;
      k = 0;
      p = clock_out_pin_o;
      repeat (64) begin
        @(posedge clk_i);
        n += (core_clock_en_o === 1'b1);
        k += (clock_out_pin_o !== p);
        p = clock_out_pin_o;
      end
      chk(n, (c == 0) ? 64 : 64 >> c);
      chk(k, n);
    end
    // time base periods; a new select waits for the running period
    bus(1'b1, CSR_A, 32'h02);
    chk_bit(clock_out_pin_oe_o, 1'b0);
    // flag is stale from the earlier periods; clear it so the tick sees a fresh end
    bus(1'b0, CSR_A, 0);
    tick(t0);
    bus(1'b0, CSR_A, 0);
    chk(rd, 32'h03);
    bus(1'b0, CSR_A, 0);
    chk(rd, 32'h02);
    for (k = 1; k < 4; k++) begin
      bus(1'b1, CSR_A, 32'h02 | (k << 2));
      tick(t1);
      chk(t1 - t0, tb_len(k - 1));
      bus(1'b0, CSR_A, 0);
      tick(t0);
      chk(t0 - t1, tb_len(k));
      bus(1'b0, CSR_A, 0);
    end
    // status, enable and clear registers, and the enable gate
    bus(1'b1, EN_A, 32'h1);
    tick(t1);
    chk_bit(irq_o, 1'b1);
    bus(1'b1, EN_A, 32'h0);
    chk_bit(irq_o, 1'b0);
    bus(1'b1, EN_A, 32'h1);
    bus(1'b1, CLR_A, 32'h1);
    chk_bit(irq_o, 1'b0);
    bus(1'b0, STAT_A, 0);
    chk(rd, 0);
    bus(1'b1, CSR_A, 32'h0c);
    chk_bit(tb_irq_o, 1'b0);
    bus(1'b1, CSR_A, 32'h82);
    chk_bit(tb_irq_o, 1'b1);
    bus(1'b0, CSR_A, 0);
    // active halt: write ignored, counter runs, time base wakes
    tick(t1);
    bus(1'b0, CSR_A, 0);
    halt_instr_i <= 1'b1;
    @(posedge clk_i);
    halt_instr_i <= 1'b0;
    @(posedge clk_i);
    chk_bit(active_halt_o, 1'b1);
    bus(1'b1, CSR_A, 32'h02);
    chk_bit(clock_out_pin_o, 1'b0);
    tick(t0);
    chk(t0 - t1, TB0);
    @(posedge clk_i);
    chk_bit(active_halt_o, 1'b0);
    bus(1'b0, CSR_A, 0);
    chk(rd, 32'h83);
    // full halt: nothing but the external wake ends it
    bus(1'b1, CSR_A, 32'h00);
    halt_instr_i <= 1'b1;
    @(posedge clk_i);
    halt_instr_i <= 1'b0;
    repeat (60) @(posedge clk_i);
    chk_bit(halt_o, 1'b1);
    ext_wake_i <= 1'b1;
    @(posedge clk_i);
    ext_wake_i <= 1'b0;
    @(posedge clk_i);
    chk_bit(halt_o, 1'b0);
    bus(1'b0, STAT_A, 0);
    chk(rd & 32'h2, 32'h2);
    // wait mode keeps counting and the request wakes the core
    bus(1'b1, CSR_A, 32'h02);
    wait_i <= 1'b1;
    tick(t0);
    chk_bit(wake_o, 1'b1);
    wait_i <= 1'b0;
    bus(1'b0, CSR_A, 0);
    // tone codes with random reserved bits; half period per code
    for (c = 1; c < 4; c++) begin
      m = $random(seed);
      bus(1'b1, TONE_A, (m & 32'hfc) | c);
      bus(1'b0, TONE_A, 0);
      chk(rd, c);
      flip(t0);
      flip(t1);
      chk(t1 - t0, (c == 1) ? TH1 : (c == 2) ? TH2 : TH3);
    end
    // a write without lane 0 is refused and leaves the tone code alone
    sel0 = 1'b0;
    bus(1'b1, TONE_A, 0);
    sel0 = 1'b1;
    bus(1'b0, TONE_A, 0);
    chk(rd, 3);
    bus(1'b1, TONE_A, 0);
    chk_bit(tone_pin_oe_o, 1'b0);
    repeat (4) @(posedge clk_i);
    end_of_test();
  end
endmodule : testbench

bind ckc_top ckc_top_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .halt_instr_i, .wait_i, .ext_wake_i, .active_halt_o, .halt_o, .wake_o, .core_clock_en_o,
  .clock_out_pin_o, .clock_out_pin_oe_o, .tone_pin_oe_o, .tone_pin_o, .tb_irq_o);
